/* verilog/alt_reload_wave_timer.sv */
/*
  alternating-reload waveform timer: 8-bit prescaler and 8-bit down counter
  that count a primary and a secondary value in turn and toggle a pin.
  assumes one 50 MHz clock mclk, enables for ring oscillator and subclock,
  and an axi4-lite master that keeps one write and one read in flight.
*/
// Functional notes
// - count primary and secondary values in turn, toggle pin at each underflow
// - the first period after start is always the primary period
// - count source is sysclk, sysclk/8, ring oscillator or subclock/32
// - count down, reload primary and secondary alternately on underflow
// - on stop, load the counter from reload register before halting
// - prescaler divides by n+1; full cycle is (m+1)+(l+1) prescaled ticks
// - start flag one starts counting, zero stops it
// - stop sets request flag; software masks and clears around it
// - request only at secondary-period underflow or stop, never at primary underflow
// - primary and prescaler reads return the live counts
// - writes touch only reload registers, never the running counters
// - secondary and extend bits wait for a primary write, apply next primary
// - stopped pin holds the secondary period level
// - level latch select sets primary and secondary output levels
// - switch bit picks toggling wave or port latch, at secondary underflow or while stopped
// - extend bits lengthen a period by half a count source cycle on sysclk/8 and subclock/32, a whole one on sysclk and ring oscillator
`timescale 1ns/100ps
module alt_reload_wave_timer
  import wave_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ringOscTick,
  input wire logic subclkTick,
  output logic wave_out_pin,
  output logic irqOut
);

  // ------------------------------------------------------------------
  // registers and wires
  // ------------------------------------------------------------------
  logic wrEn;
  logic rdEn;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic [7:0] rdAddr;
  logic [7:0] rdValue;
  logic srcTick;
  logic srcHalfTick;
  logic [7:0] mode_q;
  logic [7:0] waveCtl_q;
  logic [7:0] priReload_q;
  logic [7:0] secReload_q;
  logic [7:0] secPending_q;
  logic [1:0] extPending_q;
  logic [1:0] extActive_q;
  logic [7:0] secActive_q;
  logic [7:0] presReload_q;
  logic [7:0] presCnt_q;
  logic [7:0] cnt_q;
  logic [1:0] irqStat_q;
  logic [1:0] irqMask_q;
  logic extWait_q;
  logic halfAlign_q;
  logic wave_q;
  logic outSel_q;
  logic portVal_q;
  logic startDly_q;
  phase_t phase_q;
  phase_t phase_d;

  // ------------------------------------------------------------------
  // bus front end and count source
  // ------------------------------------------------------------------
  axil_reg_port busPort (
    .mclk(mclk),
    .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .rdEn(rdEn),
    .rdAddr(rdAddr),
    .rdValue(rdValue)
  );

  wave_src_sel srcSel (
    .mclk(mclk),
    .reset_n(reset_n),
    .srcSel(mode_q[SRC_HI:SRC_LO]),
    .ringOscTick(ringOscTick),
    .subclkTick(subclkTick),
    .srcTick(srcTick),
    .srcHalfTick(srcHalfTick)
  );

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  wire wrMode = wrEn && wrAddr == MODE_OFS;
  wire wrWave = wrEn && wrAddr == WAVECTL_OFS;
  wire wrPri = wrEn && wrAddr == PRIMARY_OFS;
  wire wrSec = wrEn && wrAddr == SECONDARY_OFS;
  wire wrPres = wrEn && wrAddr == PRESCALE_OFS;
  wire wrStat = wrEn && wrAddr == IRQSTAT_OFS;
  wire wrMask = wrEn && wrAddr == IRQMASK_OFS;
  wire startFlag = mode_q[START_BIT];
  wire levelSel = mode_q[LEVEL_SEL_BIT];
  wire running = phase_q != IDLE_S;
  wire startReq = startFlag && !startDly_q;
  wire stopReq = !startFlag && startDly_q;
  wire [1:0] stagedExt = {waveCtl_q[SEC_EXT_BIT], waveCtl_q[PRI_EXT_BIT]};

  // after an odd number of extended periods the count runs on the half ticks,
  // so later periods keep their full length from the shifted edge
  wire cntTick = halfAlign_q ? srcHalfTick : srcTick;
  wire altTick = halfAlign_q ? srcTick : srcHalfTick;

  // prescaler gives the timer one tick per n+1 source ticks
  wire presZero = presCnt_q == '0;
  wire presTick = running && cntTick && presZero;
  wire cntZero = cnt_q == '0;
  wire curExt = phase_q == PRI_S ? extActive_q[0] : extActive_q[1];

  // an extended period runs on to the opposite tick of the source
  wire zeroHit = presTick && cntZero;
  wire underflow = extWait_q ? altTick : (zeroHit && !curExt);
  wire priUnder = running && underflow && phase_q == PRI_S;
  wire secUnder = running && underflow && phase_q == SEC_S;

  // live primary and prescaler counts are read back rather than the reload values
  assign rdValue = rdAddr == MODE_OFS ? mode_q :
                   rdAddr == WAVECTL_OFS ? waveCtl_q :
                   rdAddr == PRIMARY_OFS ? cnt_q :
                   rdAddr == SECONDARY_OFS ? secPending_q :
                   rdAddr == PRESCALE_OFS ? presCnt_q :
                   rdAddr == IRQSTAT_OFS ? {6'h00, irqStat_q} :
                   rdAddr == IRQMASK_OFS ? {6'h00, irqMask_q} : 8'h00;

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= REG_RESET;
      waveCtl_q <= REG_RESET;
      irqMask_q <= '0;
      startDly_q <= 1'b0;
    end else begin
      startDly_q <= startFlag;
      if (wrMode) begin
        mode_q <= wrData;
      end
      if (wrWave) begin
        waveCtl_q <= wrData;
      end
      if (wrMask) begin
        irqMask_q <= wrData[1:0];
      end
    end
  end

  // reload registers: secondary and extend bits are staged behind a
  // primary write so a pair of values always changes together
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      priReload_q <= COUNT_RESET;
      secPending_q <= COUNT_RESET;
      secReload_q <= COUNT_RESET;
      extPending_q <= '0;
      presReload_q <= REG_RESET;
    end else begin
      if (wrSec) begin
        secPending_q <= wrData;
      end
      if (wrPri) begin
        priReload_q <= wrData;
        secReload_q <= secPending_q;
        extPending_q <= stagedExt;
      end
      if (wrPres) begin
        presReload_q <= wrData;
      end
    end
  end

  // ------------------------------------------------------------------
  // phase sequencer
  // ------------------------------------------------------------------
  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      IDLE_S: begin
        if (startReq) begin
          phase_d = PRI_S;
        end
      end
      PRI_S: begin
        if (stopReq) begin
          phase_d = IDLE_S;
        end else if (underflow) begin
          phase_d = SEC_S;
        end
      end
      SEC_S: begin
        if (stopReq) begin
          phase_d = IDLE_S;
        end else if (underflow) begin
          phase_d = PRI_S;
        end
      end
      default: begin
        phase_d = IDLE_S;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= IDLE_S;
    end else begin
      phase_q <= phase_d;
    end
  end

  // ------------------------------------------------------------------
  // counters
  // ------------------------------------------------------------------
  // pending values go live at the start of each primary period
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      presCnt_q <= COUNT_RESET;
      cnt_q <= COUNT_RESET;
      secActive_q <= COUNT_RESET;
      extActive_q <= '0;
      extWait_q <= 1'b0;
      halfAlign_q <= 1'b0;
    end else if (stopReq || !running) begin
      presCnt_q <= presReload_q;
      cnt_q <= priReload_q;
      secActive_q <= secReload_q;
      extActive_q <= extPending_q;
      extWait_q <= 1'b0;
      halfAlign_q <= 1'b0;
    end else begin
      if (cntTick) begin
        presCnt_q <= presZero ? presReload_q : presCnt_q - 8'h01;
      end
      extWait_q <= extWait_q ? !altTick : (zeroHit && curExt);
      halfAlign_q <= halfAlign_q ^ (extWait_q && altTick);
      if (underflow && phase_q == PRI_S) begin
        cnt_q <= secActive_q;
      end else if (underflow) begin
        cnt_q <= priReload_q;
        secActive_q <= secReload_q;
        extActive_q <= extPending_q;
      end else if (presTick && !cntZero) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  // ------------------------------------------------------------------
  // waveform output
  // ------------------------------------------------------------------
  // primary level is the latch select, secondary its inverse
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wave_q <= 1'b1;
      outSel_q <= 1'b0;
      portVal_q <= 1'b0;
    end else begin
      if (!running && startReq) begin
        wave_q <= levelSel;
      end else if (!running || stopReq) begin
        wave_q <= !levelSel;
      end else if (underflow) begin
        wave_q <= !wave_q;
      end
      if (secUnder || !running) begin
        outSel_q <= waveCtl_q[OUT_SWITCH_BIT];
        portVal_q <= waveCtl_q[PORT_LATCH_BIT];
      end
    end
  end

  // while running, switching waits for a secondary underflow to avoid a runt pulse
  assign wave_out_pin = outSel_q ? portVal_q : wave_q;

  // ------------------------------------------------------------------
  // interrupt status
  // ------------------------------------------------------------------
  // a new event in the clearing cycle wins over the write-one clear
  wire [1:0] irqSet = {priUnder, secUnder || stopReq};
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irqStat_q <= '0;
    end else begin
      irqStat_q <= (irqStat_q & ~(wrStat ? wrData[1:0] : 2'h0)) | irqSet;
    end
  end

  assign irqOut = |(irqStat_q & irqMask_q);

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  first_primary_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    phase_q == IDLE_S && startReq |=> phase_q == PRI_S)
    else $error("start did not enter primary period");

  alternate_phase_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    priUnder && !stopReq |=> phase_q == SEC_S && cnt_q == $past(secActive_q))
    else $error("primary underflow did not load secondary");

  wave_toggle_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    running && underflow && !stopReq |=> wave_q != $past(wave_q))
    else $error("wave did not invert at underflow");

  stop_reload_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    stopReq |=> phase_q == IDLE_S && cnt_q == $past(priReload_q) && irqStat_q[IRQ_TIMER_BIT])
    else $error("stop did not reload and flag");

  sec_irq_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    secUnder |=> irqStat_q[IRQ_TIMER_BIT])
    else $error("secondary underflow did not raise request");

  no_pri_irq_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    !irqStat_q[IRQ_TIMER_BIT] && !secUnder && !stopReq |=> !irqStat_q[IRQ_TIMER_BIT])
    else $error("request raised outside secondary underflow");

  write_only_reload_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    running && wrPri && !presTick && !underflow && !stopReq |=> $stable(cnt_q))
    else $error("primary write reached the counter");

  stopped_level_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    !running && !startReq ##1 !running |-> wave_q == !$past(levelSel))
    else $error("stopped pin not at secondary level");

  out_switch_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    running && $past(running) && !$past(stopReq) && $changed(outSel_q) |-> $past(secUnder))
    else $error("output switched away from secondary underflow");

  irq_out_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    irqSet[0] && irqMask_q[0] && !wrMask |=> irqOut)
    else $error("unmasked event did not raise interrupt");

endmodule

/* inc/wave_timer_pkg.sv */
/*
  shared constants of the alternating-reload waveform timer: register byte
  offsets, field positions, reset values and count source dividers.
  assumes a 32-bit axi4-lite register bus with 8-bit registers in the low lane.
*/
package wave_timer_pkg;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] WAVECTL_OFS = 8'h04;
  localparam logic [7:0] PRIMARY_OFS = 8'h08;
  localparam logic [7:0] SECONDARY_OFS = 8'h0c;
  localparam logic [7:0] PRESCALE_OFS = 8'h10;
  localparam logic [7:0] IRQSTAT_OFS = 8'h14;
  localparam logic [7:0] IRQMASK_OFS = 8'h18;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int SRC_LO = 0;            // mode: count source select, 2 bits
  localparam int SRC_HI = 1;
  localparam int START_BIT = 3;         // mode: count start flag
  localparam int LEVEL_SEL_BIT = 4;     // mode: output level latch select
  localparam int PORT_LATCH_BIT = 0;    // wavectl: port latch output value
  localparam int OUT_SWITCH_BIT = 1;    // wavectl: output switching bit
  localparam int PRI_EXT_BIT = 4;       // wavectl: primary half-cycle extend
  localparam int SEC_EXT_BIT = 5;       // wavectl: secondary half-cycle extend
  localparam int IRQ_TIMER_BIT = 0;     // status: secondary underflow or stop
  localparam int IRQ_PRI_BIT = 1;       // status: primary underflow event

  // ------------------------------------------------------------------
  // reset values and count sources
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'hff;
  localparam logic [1:0] SRC_SYSCLK = 2'h0;
  localparam logic [1:0] SRC_DIV8 = 2'h1;
  localparam logic [1:0] SRC_RING = 2'h2;
  localparam logic [1:0] SRC_SUB32 = 2'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;
  localparam logic [2:0] DIV8_HALF = 3'h3;
  localparam logic [4:0] DIV32_LAST = 5'h1f;
  localparam logic [4:0] DIV32_HALF = 5'h0f;

  typedef enum logic [1:0] {
    IDLE_S = 2'h0,
    PRI_S = 2'h1,
    SEC_S = 2'h3
  } phase_t;

endpackage

/* verilog/wave_src_sel.sv */
/*
  count source selector: turns the chosen source into a tick enable and a
  mid-period half tick for the half-cycle extension.
  assumes ring oscillator and subclock arrive as one-cycle enables on mclk.
*/
`timescale 1ns/100ps
module wave_src_sel
  import wave_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [1:0] srcSel,
  input wire logic ringOscTick,
  input wire logic subclkTick,
  output logic srcTick,
  output logic srcHalfTick
);

  logic [2:0] div8_q;
  logic [4:0] div32_q;
  wire div8End = div8_q == DIV8_LAST;
  wire div8Mid = div8_q == DIV8_HALF;
  wire sub32End = subclkTick && div32_q == DIV32_LAST;
  wire sub32Mid = subclkTick && div32_q == DIV32_HALF;

  // ------------------------------------------------------------------
  // free running dividers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div8_q <= '0;
      div32_q <= '0;
    end else begin
      div8_q <= div8_q + 3'h1;
      if (subclkTick) begin
        div32_q <= div32_q + 5'h1;
      end
    end
  end

  // undivided sources have no half point, so the half tick is the tick
  assign srcTick = srcSel == SRC_SYSCLK ? 1'b1 :
                   srcSel == SRC_DIV8 ? div8End :
                   srcSel == SRC_RING ? ringOscTick : sub32End;
  assign srcHalfTick = srcSel == SRC_DIV8 ? div8Mid :
                       srcSel == SRC_SUB32 ? sub32Mid : srcTick;

endmodule

/* verilog/axil_reg_port.sv */
/*
  axi4-lite slave front end: takes one write and one read at a time and
  hands them to the register file as strobes.
  assumes the register file decodes offsets and supplies read data combinationally.
*/
`timescale 1ns/100ps
module axil_reg_port
  import wave_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wrEn,
  output logic [7:0] wrAddr,
  output logic [7:0] wrData,
  output logic rdEn,
  output logic [7:0] rdAddr,
  input wire logic [7:0] rdValue
);

  logic bvalid_q;
  logic rvalid_q;
  logic [7:0] rdata_q;

  // both write channels are taken together, once the last response is gone
  wire wrTake = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  wire rdTake = s_axi_arvalid && !rvalid_q;
  assign s_axi_awready = wrTake;
  assign s_axi_wready = wrTake;
  assign s_axi_arready = rdTake;
  assign wrEn = wrTake && s_axi_wstrb[0];
  assign wrAddr = s_axi_awaddr;
  assign wrData = s_axi_wdata[7:0];
  assign rdEn = rdTake;
  assign rdAddr = s_axi_araddr;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_bresp = 2'h0;
  assign s_axi_rresp = 2'h0;
  assign s_axi_rdata = {24'h000000, rdata_q};

  // ------------------------------------------------------------------
  // response registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      bvalid_q <= wrTake || (bvalid_q && !s_axi_bready);
      rvalid_q <= rdTake || (rvalid_q && !s_axi_rready);
      if (rdTake) begin
        rdata_q <= rdValue;
      end
    end
  end

endmodule

/* test/wave_pin_monitor.sv */
/*
  far-side model: a load on the waveform pin that times each level run.
  assumes the pin changes only just after a rising edge of mclk.
*/
`timescale 1ns/100ps
module wave_pin_monitor (
  input wire logic mclk,
  input wire logic wave_out_pin,
  output int lowLen,
  output int highLen
);
  // ----------------------------------------
  // run timing
  // ----------------------------------------
  int run = 0;
  logic last = 1'bx;

  // a run closes on each change, so its length counts the edges it lasted
  always @(posedge mclk) begin
    if (wave_out_pin !== last) begin
      if (last === 1'b1) highLen <= run;
      else lowLen <= run;
      run <= 1;
    end else begin
      run <= run + 1;
    end
    last <= wave_out_pin;
  end
endmodule

/* test/testbench.sv */
/*
  self-checking bench: drives the timer over axi4-lite and judges the pin.
  assumes system clock source, so one source tick per mclk cycle, except the extend test on sysclk/8 and ring oscillator.
*/
`timescale 1ns/100ps
module testbench
  import wave_timer_pkg::*;
;
  // ----------------------------------------
  // stimulus and wiring
  // ----------------------------------------
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, wave_out_pin, irqOut;
  logic [31:0] rdata;
  int lowLen, highLen;
  int fail_count = 0;
  int compares = 0;

  always #10 mclk = ~mclk;

  // ring oscillator enable every fourth cycle; the subclock input shares it
  logic [1:0] ringDiv = 2'h0;
  wire ringTick = ringDiv == 2'h3;
  always @(posedge mclk) ringDiv <= ringDiv + 2'h1;

  alt_reload_wave_timer i_dut (.mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ringOscTick(ringTick),
    .subclkTick(ringTick), .wave_out_pin(wave_out_pin), .irqOut(irqOut));

  wave_pin_monitor i_load (.mclk(mclk), .wave_out_pin(wave_out_pin), .lowLen(lowLen),
    .highLen(highLen));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task close_out;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // every wait is bounded so a dead handshake ends the run
  task guard(inout int n);
    n++;
    if (n > 2000) begin
      fail_count++;
      $display("BAD %0t wait ran out", $time);
      close_out;
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin @(posedge mclk); guard(n); end while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do begin @(posedge mclk); guard(n); end while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge mclk);
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin @(posedge mclk); guard(n); end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin @(posedge mclk); guard(n); end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
    @(posedge mclk);
  endtask

  task wait_pin(input logic v, output int n);
    n = 0;
    while (wave_out_pin !== v) begin @(posedge mclk); guard(n); end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    logic [31:0] d;
    rd(PRIMARY_OFS, d);
    chk(d, 32'hff);
    rd(8'h1c, d);
    chk(d, 32'h0);
    chk(wave_out_pin, 1'b1);
    chk(irqOut, 1'b0);
    $display("reset test done");
  endtask

  // prescale 1, primary 2, secondary 20: runs of 6 low and 42 high
  task t_wave;
    logic [31:0] d;
    int n;
    wr(PRESCALE_OFS, 8'h01);
    wr(SECONDARY_OFS, 8'h14);
    wr(PRIMARY_OFS, 8'h02);
    wr(IRQSTAT_OFS, 8'h03);
    wr(IRQMASK_OFS, 8'h01);
    wr(MODE_OFS, 8'h08);
    wait_pin(1'b0, n);
    chk(n < 8, 1'b1);
    wait_pin(1'b1, n);
    rd(IRQSTAT_OFS, d);
    chk(d, 32'h02);
    chk(lowLen, 6);
    chk(irqOut, 1'b0);
    repeat (120) @(posedge mclk);
    chk(lowLen, 6);
    chk(highLen, 42);
    chk(irqOut, 1'b1);
    $display("wave test done");
  endtask

  // software masks and clears before stopping, as a careful driver would
  task t_stop;
    logic [31:0] d;
    int n;
    wait_pin(1'b1, n);
    wr(IRQMASK_OFS, 8'h00);
    chk(irqOut, 1'b0);
    wr(IRQSTAT_OFS, 8'h03);
    wr(MODE_OFS, 8'h00);
    rd(IRQSTAT_OFS, d);
    chk(d, 32'h01);
    chk(wave_out_pin, 1'b1);
    wr(MODE_OFS, 8'h10);
    repeat (3) @(posedge mclk);
    chk(wave_out_pin, 1'b0);
    wr(WAVECTL_OFS, 8'h03);
    repeat (3) @(posedge mclk);
    chk(wave_out_pin, 1'b1);
    wr(WAVECTL_OFS, 8'h02);
    repeat (3) @(posedge mclk);
    chk(wave_out_pin, 1'b0);
    $display("stop test done");
  endtask

  // sysclk/8, primary extended: 2.5 ticks of 8 high, 4 ticks low; then ring, 4 cycles a tick
  task t_ext;
    wr(WAVECTL_OFS, 8'h10);
    wr(PRESCALE_OFS, 8'h00);
    wr(SECONDARY_OFS, 8'h03);
    wr(PRIMARY_OFS, 8'h01);
    wr(IRQSTAT_OFS, 8'h03);
    wr(MODE_OFS, 8'h19);
    repeat (200) @(posedge mclk);
    chk(highLen, 20);
    chk(lowLen, 32);
    wr(MODE_OFS, 8'h10);
    wr(WAVECTL_OFS, 8'h00);
    wr(PRIMARY_OFS, 8'h01);
    wr(IRQSTAT_OFS, 8'h03);
    wr(MODE_OFS, 8'h1a);
    repeat (100) @(posedge mclk);
    chk(highLen, 8);
    chk(lowLen, 16);
    $display("extend test done");
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_wave;
    t_stop;
    t_ext;
    close_out;
  end
endmodule
